// ==== verilog/config_fuse_pkg.sv ====
// constants, field layout and carrier types of the configuration byte bank
// assumes one 25 MHz clock and a core that reaches the bank by table access
//
// What this block does
// [R01] postscale code n divides watchdog by 2**n
// [R02] hardware enable forces watchdog on, else software
// [R03] reset pin enable: reset on, input off
// [R04] bit 2 selects low-power secondary oscillator
// [R05] bit 1 sets analog default of five pins
// [R06] route bit picks primary or alternate pin
// [R07] debugger bit zero enables debugger, reserves pins
// [R08] bit 6 enables extended instruction set
// [R09] boot block size code selects block words
// [R10] dedicated debug port only on large package
// [R11] bit 2 enables single-supply programming entry
// [R12] stack fault reset enable triggers device reset
// [R13] code protect bits zero protect blocks
// [R14] zero protects eeprom and boot block code
// [R15] write protect bits zero block self-writes
// [R16] zero write-protects eeprom and boot block
// [R17] config write protect changes only in programming
// [R18] table read protect blocks cross-block reads
// [R19] unimplemented bits always read as zero
// [R20] table access only, zero means programmed
// [R21] watchdog base period 4 ms times ratio
// [R22] write start begins timed byte write
// [R23] clearable bits clear freely, set by erase
package config_fuse_pkg;

    // =====================================================================
    // bank layout
    localparam int          NUM_BYTES = 8;
    localparam logic [21:0] ADDR_WDT  = 22'h300003;
    localparam logic [21:0] ADDR_PIN  = 22'h300005;
    localparam logic [21:0] ADDR_DBG  = 22'h300006;
    localparam logic [21:0] ADDR_CPB  = 22'h300008;
    localparam logic [21:0] ADDR_CPBD = 22'h300009;
    localparam logic [21:0] ADDR_WPB  = 22'h30000a;
    localparam logic [21:0] ADDR_WPBD = 22'h30000b;
    localparam logic [21:0] ADDR_TRP  = 22'h30000c;
    localparam logic [NUM_BYTES-1:0][21:0] BANK_ADDR = {ADDR_TRP, ADDR_WPBD, ADDR_WPB,
        ADDR_CPBD, ADDR_CPB, ADDR_DBG, ADDR_PIN, ADDR_WDT};

    // index of each byte in the bank
    localparam logic [2:0] IDX_WDT  = 3'h0;
    localparam logic [2:0] IDX_PIN  = 3'h1;
    localparam logic [2:0] IDX_DBG  = 3'h2;
    localparam logic [2:0] IDX_CPB  = 3'h3;
    localparam logic [2:0] IDX_CPBD = 3'h4;
    localparam logic [2:0] IDX_WPB  = 3'h5;
    localparam logic [2:0] IDX_WPBD = 3'h6;
    localparam logic [2:0] IDX_TRP  = 3'h7;

    // unprogrammed values, implemented bits, clear-only bits
    localparam logic [NUM_BYTES-1:0][7:0] RESET_VAL  =
        {8'h03, 8'he0, 8'h03, 8'hc0, 8'h03, 8'h85, 8'h83, 8'h1f};
    localparam logic [NUM_BYTES-1:0][7:0] IMPL_MASK  =
        {8'h03, 8'he0, 8'h03, 8'hc0, 8'h03, 8'hfd, 8'h87, 8'h1f};
    localparam logic [NUM_BYTES-1:0][7:0] CLEAR_MASK =
        {8'h03, 8'hc0, 8'h03, 8'hc0, 8'h03, 8'h00, 8'h00, 8'h00};

    // =====================================================================
    // field positions
    localparam int BIT_WDT_EN   = 0;
    localparam int LSB_WDT_PS   = 1;
    localparam int BIT_RST_PIN  = 7;
    localparam int BIT_LP_OSC   = 2;
    localparam int BIT_ANALOG   = 1;
    localparam int BIT_ROUTE    = 0;
    localparam int BIT_DEBUG    = 7;
    localparam int BIT_EXTENDED_INSTR_ENABLE    = 6;
    localparam int LSB_BOOT     = 4;
    localparam int BIT_DBG_PORT = 3;
    localparam int BIT_LVP      = 2;
    localparam int BIT_STACK    = 0;
    localparam int BIT_BLK1     = 1;
    localparam int BIT_BLK0     = 0;
    localparam int BIT_EEPROM   = 7;
    localparam int BIT_BOOT     = 6;
    localparam int BIT_CONFIG   = 5;

    // =====================================================================
    // sizes and timing
    localparam logic [10:0] BOOT_WORDS_LARGE = 11'd1024;
    localparam logic [10:0] BOOT_WORDS_MID   = 11'd512;
    localparam logic [10:0] BOOT_WORDS_SMALL = 11'd256;
    localparam int          CLK_HZ           = 25_000_000;
    localparam int          WDT_BASE_MS      = 4;
    localparam int          WDT_BASE_CYCLES  = CLK_HZ / 1000 * WDT_BASE_MS;
    localparam int          LONG_WRITE_CYCLES = 64;

    // =====================================================================
    // carrier types
    typedef struct packed {
        logic [21:0] addr;   // table pointer
        logic [7:0]  wdata;  // table latch data
        logic        rd;     // table read strobe
        logic        wr;     // table write strobe
    } tbl_req_t;

    typedef struct packed {
        logic [3:0]  watchdog_postscale_select;
        logic        watchdog_hw_enable;
        logic        reset_pin_enable;
        logic        low_power_secondary_osc;
        logic [4:0]  port_analog_default;
        logic        capture_compare2_route;
        logic        debugger_enable;
        logic        debug_pins_reserved;
        logic        extended_instr_enable;
        logic [10:0] boot_block_words;
        logic        dedicated_debug_port_enable;
        logic        single_supply_prog_enable;
        logic        stack_fault_reset_enable;
    } settings_t;

    // each flag high means its region is protected
    typedef struct packed {
        logic [1:0] code_block;
        logic       code_eeprom;
        logic       code_boot;
        logic [1:0] write_block;
        logic       write_eeprom;
        logic       write_boot;
        logic       write_config;
        logic [1:0] read_block;
    } protect_t;

endpackage

// ==== verilog/wdt_postscale_timer.sv ====
// watchdog base tick counter with a selectable power-of-two postscaler
// assumes enable and clear come from logic on the same clock
`timescale 1ns/1ps
module wdt_postscale_timer #(
    parameter int BASE_CYCLES = 100000
) (
    input  wire logic       i_clk,     // system clock
    input  wire logic       i_rst,     // sync reset, high
    input  wire logic       i_ce,      // clock enable
    input  wire logic       i_enable,  // watchdog running
    input  wire logic       i_clear,   // clear counts
    input  wire logic [3:0] i_ps,      // postscale code
    output logic            o_timeout  // one-cycle timeout
);
    localparam int BW = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;

    if (BASE_CYCLES < 1) begin : g_bad_base
        $error("base period must be at least one cycle");
    end

    logic [BW-1:0] base_cnt;
    logic [15:0]   post_cnt;
    logic          tick;
    logic [15:0]   ratio_m1;
    logic          hold;

    // tick once per base period, ratio is 2**code
    assign tick     = (base_cnt == BW'(BASE_CYCLES - 1));
    assign ratio_m1 = 16'((17'h00001 << i_ps) - 17'h00001);  // R01
    assign hold     = !i_enable || i_clear;

    // base period counter
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            base_cnt <= '0;
        end else if (i_ce) begin
            if (hold || tick) begin
                base_cnt <= '0;
            end else begin
                base_cnt <= base_cnt + BW'(1);  // R21
            end
        end
    end

    // postscaler and timeout pulse
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            post_cnt  <= '0;
            o_timeout <= 1'b0;
        end else if (i_ce) begin
            o_timeout <= !hold && tick && (post_cnt == ratio_m1);  // R21
            if (hold) begin
                post_cnt <= '0;
            end else if (tick) begin
                post_cnt <= (post_cnt == ratio_m1) ? 16'h0000 : post_cnt + 16'h0001;
            end
        end
    end
endmodule

// ==== verilog/config_fuse_bank_decode.sv ====
// configuration byte bank: table access, timed byte write, decoded settings
// assumes table strobes and control inputs are on i_clk; the reset pin is not
`timescale 1ns/1ps
module config_fuse_bank_decode
    import config_fuse_pkg::*;
#(
    parameter int WDT_BASE     = WDT_BASE_CYCLES,
    parameter int WRITE_CYCLES = LONG_WRITE_CYCLES,
    parameter bit LARGE_PART   = 1'b1,
    parameter bit LARGE_PKG    = 1'b1
) (
    input  wire logic     i_clk,                 // 25 MHz clock
    input  wire logic     i_rst,                 // sync reset, high
    input  wire logic     i_ce,                  // clock enable
    input  wire tbl_req_t i_tbl,                 // table read/write request
    input  wire logic     i_wr_start,            // write-start control bit
    input  wire logic     i_prog_mode,           // device in programming mode
    input  wire logic     i_bulk_erase,          // full erase request
    input  wire logic     i_watchdog_sw_enable,  // software watchdog enable
    input  wire logic     i_wdt_clear,           // clear watchdog counts
    input  wire logic     i_stack_fault,         // stack full or underflow
    input  wire logic     i_reset_pin_n,         // shared reset/input pin
    output logic [7:0]    o_rd_data,             // table read data
    output logic          o_rd_valid,            // read data valid pulse
    output logic          o_wr_busy,             // long write in progress
    output logic          o_wr_done,             // write finished pulse
    output logic          o_wr_refused,          // write dropped pulse
    output settings_t     o_settings,            // decoded settings
    output protect_t      o_protect,             // protection flags
    output logic          o_watchdog_run,        // watchdog running
    output logic          o_watchdog_timeout,    // watchdog timeout pulse
    output logic          o_ext_reset,           // external reset request
    output logic          o_shared_input,        // general input value
    output logic          o_stack_reset          // stack fault reset request
);
    typedef enum logic {ST_IDLE, ST_WRITE} wr_state_t;

    localparam int WCW = (WRITE_CYCLES > 1) ? $clog2(WRITE_CYCLES) : 1;

    if (WRITE_CYCLES < 1 || WDT_BASE < 1) begin : g_bad_param
        $error("write time and watchdog base must be at least one cycle");
    end

    // =====================================================================
    // helpers

    // table address to bank index, bit 3 set on a hit
    function automatic logic [3:0] lookup(input logic [21:0] addr);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < NUM_BYTES; k++) begin
            if (addr == BANK_ADDR[k]) begin
                r = {1'b1, 3'(k)};
            end
        end
        return r;
    endfunction

    // merge a written byte into a stored byte
    function automatic logic [7:0] merge_byte(input logic [2:0] idx,
                                              input logic [7:0] old,
                                              input logic [7:0] data,
                                              input logic       prog);
        logic [7:0] clr;
        logic [7:0] v;
        clr = CLEAR_MASK[idx];
        v   = (old & clr & data) | (data & ~clr);  // R23
        if (idx == IDX_WPBD) begin
            v[BIT_CONFIG] = prog ? data[BIT_CONFIG] : old[BIT_CONFIG];  // R17
        end
        return v & IMPL_MASK[idx];  // R19
    endfunction

    // boot block size by size code and part size
    function automatic logic [10:0] boot_words(input logic [1:0] code);
        logic [10:0] w;
        w = BOOT_WORDS_SMALL;
        if (code != 2'b00) begin
            w = BOOT_WORDS_MID;
        end
        if (LARGE_PART && code[1]) begin
            w = BOOT_WORDS_LARGE;
        end
        return w;
    endfunction

    // =====================================================================
    // storage and write sequencer
    logic [7:0]     bank [NUM_BYTES];
    wr_state_t      state;
    logic [WCW-1:0] wr_cnt;
    logic [21:0]    wr_addr;
    logic [7:0]     wr_data;
    logic [3:0]     wr_hit;
    logic [3:0]     rd_hit;
    logic           commit;
    logic           wr_allowed;
    logic           erase_ok;

    assign wr_hit     = lookup(wr_addr);
    assign rd_hit     = lookup(i_tbl.addr);
    assign commit     = (state == ST_WRITE) && (wr_cnt == '0);
    assign wr_allowed = wr_hit[3] && (i_prog_mode || bank[IDX_WPBD][BIT_CONFIG]);  // R17
    assign erase_ok   = i_prog_mode && i_bulk_erase && (state == ST_IDLE);  // R23
    assign o_wr_busy  = (state == ST_WRITE);

    // table latch for address and data
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_addr <= '0;
            wr_data <= '0;
        end else if (i_ce && i_tbl.wr && state == ST_IDLE) begin
            wr_addr <= i_tbl.addr;  // R20
            wr_data <= i_tbl.wdata;
        end
    end

    // self-timed long write
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state        <= ST_IDLE;
            wr_cnt       <= '0;
            o_wr_done    <= 1'b0;
            o_wr_refused <= 1'b0;
        end else if (i_ce) begin
            o_wr_done    <= 1'b0;
            o_wr_refused <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_wr_start && !erase_ok) begin
                        state  <= ST_WRITE;  // R22
                        wr_cnt <= WCW'(WRITE_CYCLES - 1);
                    end
                end
                ST_WRITE: begin
                    if (commit) begin
                        state        <= ST_IDLE;
                        o_wr_done    <= 1'b1;
                        o_wr_refused <= !wr_allowed;
                    end else begin
                        wr_cnt <= wr_cnt - WCW'(1);
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // one flip-flop byte per bank entry
    for (genvar g = 0; g < NUM_BYTES; g++) begin : g_byte
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                bank[g] <= RESET_VAL[g];
            end else if (i_ce) begin
                if (erase_ok) begin
                    bank[g] <= RESET_VAL[g];  // R23
                end else if (commit && wr_allowed && wr_hit[2:0] == 3'(g)) begin
                    bank[g] <= merge_byte(3'(g), bank[g], wr_data, i_prog_mode);  // R22
                end
            end
        end
    end

    // table read, unmapped addresses read zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data  <= '0;
            o_rd_valid <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= i_tbl.rd;  // R20
            if (i_tbl.rd) begin
                o_rd_data <= rd_hit[3] ? (bank[rd_hit[2:0]] & IMPL_MASK[rd_hit[2:0]])
                                       : 8'h00;  // R19
            end
        end
    end

    // =====================================================================
    // decode
    settings_t next_settings;
    protect_t  next_protect;

    // settings and protection flags from the stored bytes
    always_comb begin
        next_settings.watchdog_postscale_select = bank[IDX_WDT][LSB_WDT_PS +: 4];  // R01
        next_settings.watchdog_hw_enable        = bank[IDX_WDT][BIT_WDT_EN];
        next_settings.reset_pin_enable          = bank[IDX_PIN][BIT_RST_PIN];  // R03
        next_settings.low_power_secondary_osc   = bank[IDX_PIN][BIT_LP_OSC];  // R04
        next_settings.port_analog_default       = {5{bank[IDX_PIN][BIT_ANALOG]}};  // R05
        next_settings.capture_compare2_route    = bank[IDX_PIN][BIT_ROUTE];  // R06
        next_settings.debugger_enable           = !bank[IDX_DBG][BIT_DEBUG];  // R07
        next_settings.debug_pins_reserved       = !bank[IDX_DBG][BIT_DEBUG];  // R07
        next_settings.extended_instr_enable     = bank[IDX_DBG][BIT_EXTENDED_INSTR_ENABLE];  // R08
        next_settings.boot_block_words          = boot_words(bank[IDX_DBG][LSB_BOOT +: 2]);  // R09
        next_settings.dedicated_debug_port_enable =
            LARGE_PKG && bank[IDX_DBG][BIT_DBG_PORT];  // R10
        next_settings.single_supply_prog_enable = bank[IDX_DBG][BIT_LVP];  // R11
        next_settings.stack_fault_reset_enable  = bank[IDX_DBG][BIT_STACK];  // R12
        next_protect.code_block   = ~bank[IDX_CPB][BIT_BLK1:BIT_BLK0];  // R13
        next_protect.code_eeprom  = !bank[IDX_CPBD][BIT_EEPROM];  // R14
        next_protect.code_boot    = !bank[IDX_CPBD][BIT_BOOT];  // R14
        next_protect.write_block  = ~bank[IDX_WPB][BIT_BLK1:BIT_BLK0];  // R15
        next_protect.write_eeprom = !bank[IDX_WPBD][BIT_EEPROM];  // R16
        next_protect.write_boot   = !bank[IDX_WPBD][BIT_BOOT];  // R16
        next_protect.write_config = !bank[IDX_WPBD][BIT_CONFIG];  // R17
        next_protect.read_block   = ~bank[IDX_TRP][BIT_BLK1:BIT_BLK0];  // R18
    end

    // registered decode outputs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_settings     <= '0;
            o_protect      <= '0;
            o_watchdog_run <= 1'b0;
        end else if (i_ce) begin
            o_settings     <= next_settings;
            o_protect      <= next_protect;
            o_watchdog_run <= next_settings.watchdog_hw_enable || i_watchdog_sw_enable;  // R02
        end
    end

    // =====================================================================
    // pins and reset requests
    logic pin_meta;
    logic pin_sync;

    // two-flop synchroniser on the shared pin
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else if (i_ce) begin
            pin_meta <= i_reset_pin_n;
            pin_sync <= pin_meta;
        end
    end

    // pin function and stack reset requests
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ext_reset    <= 1'b0;
            o_shared_input <= 1'b0;
            o_stack_reset  <= 1'b0;
        end else if (i_ce) begin
            o_ext_reset    <= next_settings.reset_pin_enable && !pin_sync;  // R03
            o_shared_input <= !next_settings.reset_pin_enable && pin_sync;  // R03
            o_stack_reset  <= next_settings.stack_fault_reset_enable && i_stack_fault;  // R12
        end
    end

    // watchdog counter
    wdt_postscale_timer #(
        .BASE_CYCLES(WDT_BASE)
    ) u_wdt (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_ce     (i_ce),
        .i_enable (o_watchdog_run),
        .i_clear  (i_wdt_clear),
        .i_ps     (o_settings.watchdog_postscale_select),
        .o_timeout(o_watchdog_timeout)
    );

    // =====================================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // sampled history is ignored across a reset edge and a frozen cycle
    a_unimpl_zero: assert property ($past(i_ce) && o_rd_valid // R19
        |-> (o_rd_data & ~IMPL_MASK[$past(rd_hit[2:0])]) == 8'h00)
        else $error("unimplemented bit read as one");
    a_unmapped_zero: assert property ($past(i_ce) && $past(i_tbl.rd) // R20
        && !$past(rd_hit[3]) |-> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_clear_only: assert property ($past(i_ce) && !$past(i_rst) && !$past(erase_ok) // R23
        |-> (bank[IDX_CPB] & ~$past(bank[IDX_CPB])) == 8'h00)
        else $error("clearable bit set without erase");
    a_config_lock: assert property (!$past(i_prog_mode) && !$past(erase_ok) // R17
        && !$past(i_rst) |-> bank[IDX_WPBD][BIT_CONFIG] == $past(bank[IDX_WPBD][BIT_CONFIG]))
        else $error("config protect changed outside programming");
    a_write_start: assert property (i_ce && state == ST_IDLE && i_wr_start // R22
        && !erase_ok |=> o_wr_busy)
        else $error("write start did not begin a write");
    a_hw_wdt_run: assert property ($past(i_ce) && !$past(i_rst) // R02
        && $past(next_settings.watchdog_hw_enable) |-> o_watchdog_run)
        else $error("watchdog off while hardware enable set");
    a_ext_reset_pin: assert property (o_ext_reset |-> !o_shared_input // R03
        && o_settings.reset_pin_enable == $past(next_settings.reset_pin_enable))
        else $error("reset and input active together");
    a_stack_reset: assert property (i_ce && i_stack_fault // R12
        && next_settings.stack_fault_reset_enable |=> o_stack_reset)
        else $error("stack fault did not request reset");
    a_debug_pins: assert property ( // R07
        o_settings.debug_pins_reserved == o_settings.debugger_enable)
        else $error("debug pins disagree with debugger");
    a_boot_size: assert property (!LARGE_PART // R09
        |-> o_settings.boot_block_words != BOOT_WORDS_LARGE)
        else $error("small part reports large boot block");
    a_boot_small: assert property ($past(i_ce) && !$past(i_rst) // R09
        && $past(bank[IDX_DBG][LSB_BOOT +: 2]) == 2'b00
        |-> o_settings.boot_block_words == BOOT_WORDS_SMALL)
        else $error("zero boot code not smallest block");
    a_erase_defaults: assert property ($past(i_ce) && !$past(i_rst) && $past(erase_ok) // R23
        |-> bank[IDX_WPBD] == RESET_VAL[IDX_WPBD])
        else $error("erase did not restore defaults");

    // main scenarios
    c_write_done: cover property (o_wr_done && !o_wr_refused);
    c_boot_mid: cover property (o_settings.boot_block_words == BOOT_WORDS_MID);
    c_write_refused: cover property (o_wr_refused);
    c_erase: cover property (erase_ok);
    c_wdt_timeout: cover property (o_watchdog_timeout);
endmodule

// ==== verif/config_fuse_bank_decode_tb_top.sv ====
// self-checking bench for the configuration byte bank and its decode
// assumes short watchdog base and write time parameters, bench drives at negedge
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module config_fuse_bank_decode_tb_top;
    import config_fuse_pkg::*;
    localparam int WDT_B = 4;
    logic i_clk = 1'b0, i_rst = 1'b1, sw_en = 1'b0, prog = 1'b0, erase = 1'b0, start = 1'b0;
    logic pin_n = 1'b1, stack = 1'b0, ce = 1'b1;
    tbl_req_t  tbl = '0;
    logic [7:0] rd_data;
    logic       rd_valid, wr_busy, wr_done, wr_refused, wd_run, wd_to, ext_rst, sh_in, stk_rst;
    settings_t  st;
    protect_t   pr;
    int         n_mismatch = 0, n_checks = 0, cyc = 0;
    // =====================================================================
    // clock, design and hang guard
    always #20 i_clk = ~i_clk;
    config_fuse_bank_decode #(.WDT_BASE(WDT_B), .WRITE_CYCLES(3)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_tbl(tbl), .i_wr_start(start),
        .i_prog_mode(prog), .i_bulk_erase(erase), .i_watchdog_sw_enable(sw_en),
        .i_wdt_clear(1'b0), .i_stack_fault(stack), .i_reset_pin_n(pin_n),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_wr_busy(wr_busy), .o_wr_done(wr_done),
        .o_wr_refused(wr_refused), .o_settings(st), .o_protect(pr), .o_watchdog_run(wd_run),
        .o_watchdog_timeout(wd_to), .o_ext_reset(ext_rst), .o_shared_input(sh_in),
        .o_stack_reset(stk_rst));
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // =====================================================================
    // shared bus cycles
    task automatic tick(int n = 1);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic rd(logic [21:0] a, logic [7:0] ex);
        tick(); tbl.addr = a; tbl.rd = 1'b1;
        tick(); tbl.rd = 1'b0;
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("rd_data", ex, rd_data)
    endtask
    task automatic wr(logic [21:0] a, logic [7:0] d, logic ref_ex);
        int k;
        tick(); tbl.addr = a; tbl.wdata = d; tbl.wr = 1'b1;
        tick(); tbl.wr = 1'b0; start = 1'b1;
        tick(); start = 1'b0;
        `CHK("wr_busy", 1'b1, wr_busy)
        for (k = 0; k < 20 && wr_done !== 1'b1; k++) tick();
        `CHK("wr_done", 1'b1, wr_done)
        `CHK("wr_refused", ref_ex, wr_refused)
        tick(2);
    endtask
    task automatic do_erase();
        tick(); prog = 1'b1; erase = 1'b1;
        tick(); erase = 1'b0; prog = 1'b0;
        tick(2);
    endtask
    // =====================================================================
    // scenarios
    task automatic t_defaults();
        int i;
        for (i = 0; i < NUM_BYTES; i++) rd(BANK_ADDR[i], RESET_VAL[i]);
        rd(22'h300004, 8'h00);
        `CHK("ps", 4'hf, st.watchdog_postscale_select)
        `CHK("run", 1'b1, wd_run)
        `CHK("analog", 5'h1f, st.port_analog_default)
        `CHK("route", 1'b1, st.capture_compare2_route)
        `CHK("dbg", 1'b0, st.debug_pins_reserved)
        `CHK("boot", BOOT_WORDS_SMALL, st.boot_block_words)
        `CHK("prot", '0, pr)
        pin_n = 1'b0; stack = 1'b1; tick(5);
        `CHK("ext_rst", 1'b1, ext_rst)
        `CHK("sh_in", 1'b0, sh_in)
        `CHK("stk", 1'b1, stk_rst)
    endtask
    task automatic t_core_opts();
        wr(ADDR_DBG, 8'h7a, 1'b0); rd(ADDR_DBG, 8'h78);
        `CHK("dbg_en", 1'b1, st.debug_pins_reserved)
        `CHK("dbg_on", 1'b1, st.debugger_enable)
        `CHK("extended_instr_enable", 1'b1, st.extended_instr_enable)
        `CHK("boot", BOOT_WORDS_LARGE, st.boot_block_words)
        `CHK("port", 1'b1, st.dedicated_debug_port_enable)
        `CHK("lvp", 1'b0, st.single_supply_prog_enable)
        `CHK("stk", 1'b0, stk_rst)
        wr(ADDR_DBG, 8'h16, 1'b0); rd(ADDR_DBG, 8'h14);
        `CHK("boot", BOOT_WORDS_MID, st.boot_block_words)
        `CHK("lvp", 1'b1, st.single_supply_prog_enable)
        wr(ADDR_PIN, 8'h04, 1'b0); tick(3);
        `CHK("lposc", 1'b1, st.low_power_secondary_osc)
        `CHK("analog", 5'h00, st.port_analog_default)
        `CHK("route", 1'b0, st.capture_compare2_route)
        `CHK("ext_rst", 1'b0, ext_rst)
        pin_n = 1'b1; tick(5);
        `CHK("sh_in", 1'b1, sh_in)
    endtask
    task automatic t_watchdog();
        int c, k, n;
        for (c = 0; c < 3; c++) begin
            sw_en = 1'b0; wr(ADDR_WDT, 8'(c << 1), 1'b0);
            `CHK("run_off", 1'b0, wd_run)
            sw_en = 1'b1; tick(2);
            `CHK("run_on", 1'b1, wd_run)
            for (k = 0; k < 100 && wd_to !== 1'b1; k++) tick();
            n = 0;
            do begin tick(); n++; end while (wd_to !== 1'b1 && n < 100);
            `CHK("wdt_period", WDT_B << c, n)
        end
        sw_en = 1'b0;
    endtask
    task automatic t_protect();
        wr(ADDR_CPB, 8'h00, 1'b0);
        `CHK("cp_blk", 2'b11, pr.code_block)
        wr(ADDR_CPB, 8'h03, 1'b0); rd(ADDR_CPB, 8'h00);
        wr(ADDR_WPB, 8'h02, 1'b0); rd(ADDR_WPB, 8'h02);
        wr(ADDR_TRP, 8'h01, 1'b0);
        `CHK("trp", 2'b10, pr.read_block)
        wr(ADDR_CPBD, 8'h40, 1'b0);
        `CHK("cp_eep", 1'b1, pr.code_eeprom)
        wr(ADDR_WPBD, 8'h00, 1'b0); rd(ADDR_WPBD, 8'h20);
        `CHK("wp_eep", 1'b1, pr.write_eeprom & pr.write_boot)
        prog = 1'b1; wr(ADDR_WPBD, 8'h00, 1'b0); prog = 1'b0;
        `CHK("wp_cfg", 1'b1, pr.write_config)
        wr(ADDR_PIN, 8'h83, 1'b1); rd(ADDR_PIN, 8'h04);
        do_erase(); rd(ADDR_CPB, 8'h03); rd(ADDR_WPBD, 8'he0);
        wr(22'h300004, 8'h00, 1'b1);
        ce = 1'b0; tbl.addr = ADDR_WDT; tbl.rd = 1'b1; tick(2);
        `CHK("frozen_rd", 1'b0, rd_valid)
        tbl.rd = 1'b0; ce = 1'b1;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        tick(5); i_rst = 1'b0; tick(2);
        t_defaults(); t_core_opts(); t_watchdog(); t_protect();
        end_of_test();
    end
endmodule
